// ### dv/spf_peer.sv
`timescale 1ns/1ps
// Serial peripheral behind the port: samples on the leading edge, shifts on the trailing edge
module spf_peer (
  input  wire logic        sckOut,
  input  wire logic        sckOe,
  input  wire logic        sdoOut,
  input  wire logic        clock_polarity,
  input  wire logic        m16,
  input  wire logic [15:0] base,
  output logic             sdiIn,
  output logic      [15:0] got,
  output int               nWords
);
  logic [15:0] rxSh;  // Capture shifter
  logic [15:0] cur;   // Word being returned
  int          idx;   // Bits sampled so far
  int          pos;   // Bit now on the line
  int          bits;  // Word length
  initial begin
    rxSh = 16'h0000;
    got = 16'h0000;
    nWords = 0;
    idx = 0;
    pos = 0;
  end
  // Word length follows the width bit
  assign bits = m16 ? 16 : 8;
  // Each word returns a fresh value
  assign cur = base + 16'(nWords) * 16'h1111;
  // Edge decode against the idle level
  always @(sckOut) begin
    if (sckOe) begin
      if (sckOut !== clock_polarity) begin
        // Leading edge: sample the port's output
        rxSh = {rxSh[14:0], sdoOut};
        idx = idx + 1;
      end else if (idx >= bits) begin
        // Last trailing edge: word complete
        got = m16 ? rxSh : {8'h00, rxSh[7:0]};
        nWords = nWords + 1;
        idx = 0;
        pos = 0;
      end else begin
        // Trailing edge: move to next bit
        pos = idx;
      end
    end
  end
  // Most significant bit first; next word's first bit waits on the line
  always @* begin
    sdiIn = cur[bits-1-pos];
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import spf_pkg::*;
  localparam logic [15:0] EN  = 16'h0001 << STAT_EN;
  localparam logic [15:0] MST = (16'h0001 << CON1_MST) | (16'h0001 << CON1_CKE);
  logic        core_clk, resetn, regWr, regRd, idleMode, sckIn, ssIn;
  logic [3:0]  regAddr;
  logic [15:0] regWdata, regRdata;
  logic        sckOut, sckOe, sdiIn, sdoOut, sdoOe, ssOut, ssOe, portIrqFlag;
  logic        clock_polarity;       // Idle level told to the peer
  logic        m16;       // Width told to the peer
  logic        hit;       // Interrupt seen in a wait
  logic [15:0] base;      // Peer reply seed
  logic [15:0] got;       // Last word at the peer
  logic [15:0] v;         // Read-back value
  logic [15:0] d;         // Random data word
  logic [2:0]  codes [3] = '{IRQ_TX_EMPTY, IRQ_TX_DONE, IRQ_RX_AVAIL};
  int          nWords, k, tgt, irqs, fails, compares, cycles;
  // Port pin seen from outside
  assign sckIn = sckOe ? sckOut : clock_polarity;
  spf_port u_dut (.core_clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .idleMode, .sckIn,
                  .sckOut, .sckOe, .sdiIn, .sdoOut, .sdoOe, .ssIn, .ssOut, .ssOe, .portIrqFlag);
  spf_peer u_peer (.sckOut, .sckOe, .sdoOut, .clock_polarity, .m16, .base, .sdiIn, .got, .nWords);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Interrupt pulse counter and run limit
  always @(posedge core_clk) begin
    if (portIrqFlag === 1'b1) irqs++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write: one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= x;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // Register read: data stands the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] x);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    x = regRdata;
  endtask
  // Bounded wait for a new interrupt pulse
  task automatic waitIrq(input int n);
    int c0;
    c0 = irqs;
    repeat (n) if (irqs == c0) @(posedge core_clk);
    hit = (irqs != c0);
  endtask
  function automatic logic [15:0] replyOf(input int n);
    logic [15:0] r;
    r = base + 16'(n) * 16'h1111;
    return m16 ? r : {8'h00, r[7:0]};
  endfunction
  // One transfer: random word out, peer word back
  task automatic xfer();
    d = m16 ? 16'($urandom) : {8'h00, 8'($urandom)};
    wr(REG_BUF, d);
    waitIrq(400);
    check("irq", 16'h0001, {15'h0, hit});
    repeat (400) if (nWords <= k) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    check("peer got", d, got);
    rd(REG_BUF, v);
    check("rx word", replyOf(k), v);
    k++;
  endtask
  initial begin
    {resetn, regWr, regRd, idleMode, clock_polarity, m16} = 6'h00;
    {ssIn, regAddr, regWdata} = {1'b1, 20'h00000};
    {base, fails, compares, cycles, irqs, k} = {16'h5a3c, 160'h0};
    void'($urandom(58183));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    rd(REG_CON1, v);
    check("con1 reset", 16'h0000, v);
    check("sck oe reset", 16'h0000, {15'h0, sckOe});
    rd(4'hf, v);
    check("unmapped", 16'h0000, v);
    // Standard master, byte words
    wr(REG_CON1, MST);
    wr(REG_STAT, 16'h0000);
    wr(REG_STAT, EN);
    repeat (2) @(posedge core_clk);
    check("sck oe", 16'h0001, {15'h0, sckOe});
    check("sdo oe", 16'h0001, {15'h0, sdoOe});
    check("ss oe", 16'h0000, {15'h0, ssOe});
    check("ss idle", 16'h0001, {15'h0, ssOut});
    repeat (4) xfer();
    // Disable, then 16-bit words with high idle clock
    wr(REG_STAT, 16'h0000);
    repeat (2) @(posedge core_clk);
    check("sck oe off", 16'h0000, {15'h0, sckOe});
    clock_polarity = 1'b1;
    m16 = 1'b1;
    wr(REG_CON1, MST | (16'h0001 << CON1_CKP) | (16'h0001 << CON1_M16));
    wr(REG_STAT, EN);
    repeat (2) @(posedge core_clk);
    check("idle clock", 16'h0001, {15'h0, sckOut});
    repeat (3) xfer();
    // Idle stop holds the transfer
    wr(REG_STAT, EN | (16'h0001 << STAT_SIDL));
    idleMode <= 1'b1;
    d = 16'($urandom);
    wr(REG_BUF, d);
    waitIrq(300);
    check("no irq in idle", 16'h0000, {15'h0, hit});
    idleMode <= 1'b0;
    waitIrq(300);
    check("irq after idle", 16'h0001, {15'h0, hit});
    repeat (3) @(posedge core_clk);
    check("peer got idle", d, got);
    rd(REG_BUF, v);
    check("rx idle", replyOf(k), v);
    k++;
    // Enhanced byte mode: fill the transmit FIFO, overfill the receive FIFO
    wr(REG_STAT, 16'h0000);
    clock_polarity = 1'b0;
    m16 = 1'b0;
    wr(REG_CON1, MST);
    wr(REG_CON2, 16'h0001 << CON2_BEN);
    wr(REG_STAT, EN);
    for (int i = 0; i < 9; i++) begin
      d = {8'h00, 8'($urandom)};
      wr(REG_BUF, d);
      if (i == 2) begin
        rd(REG_STAT, v);
        check("count pending", 16'h0002, 16'(v[10:8]));
      end
    end
    rd(REG_STAT, v);
    check("tx full", 16'h0001, 16'(v[STAT_TBF]));
    check("count eight", 16'h0000, 16'(v[10:8]));
    tgt = k + 9;
    repeat (2000) if (nWords < tgt) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    rd(REG_STAT, v);
    check("overflow", 16'h0001, 16'(v[STAT_ROV]));
    check("rx full", 16'h0001, 16'(v[STAT_RBF]));
    check("rx not empty", 16'h0000, 16'(v[STAT_RXMPT]));
    check("shifter empty", 16'h0001, 16'(v[STAT_SHIFTER_EMPTY]));
    check("tx not full", 16'h0000, 16'(v[STAT_TBF]));
    check("peer last", d, got);
    for (int i = 0; i < 8; i++) begin
      rd(REG_BUF, v);
      check("fifo word", replyOf(k + i), v);
      if (i == 0) begin
        rd(REG_STAT, v);
        check("rx full clear", 16'h0000, 16'(v[STAT_RBF]));
      end
    end
    waitIrq(6);
    check("drain irq", 16'h0001, {15'h0, hit});
    k = k + 9;
    rd(REG_STAT, v);
    check("rx empty", 16'h0001, 16'(v[STAT_RXMPT]));
    check("overflow sticky", 16'h0001, 16'(v[STAT_ROV]));
    wr(REG_STAT, EN);
    rd(REG_STAT, v);
    check("overflow cleared", 16'h0000, 16'(v[STAT_ROV]));
    // Interrupt conditions transmit empty, transmit done and receive available, one by one
    foreach (codes[j]) begin
      wr(REG_STAT, EN | (16'(codes[j]) << STAT_IRQ_CONDITION_SELECT));
      xfer();
    end
    conclude();
  end
endmodule

// ### hdl/spf_pkg.sv
package spf_pkg;
  // Register indices on the port bus
  localparam logic [3:0] REG_STAT  = 4'h0;
  localparam logic [3:0] REG_CON1  = 4'h1;
  localparam logic [3:0] REG_CON2  = 4'h2;
  localparam logic [3:0] REG_BUF   = 4'h3;
  // Status/control field positions
  localparam int STAT_EN     = 15;
  localparam int STAT_SIDL   = 13;
  localparam int STAT_BEC    = 8;
  localparam int STAT_SHIFTER_EMPTY  = 7;
  localparam int STAT_ROV    = 6;
  localparam int STAT_RXMPT  = 5;
  localparam int STAT_IRQ_CONDITION_SELECT  = 2;
  localparam int STAT_TBF    = 1;
  localparam int STAT_RBF    = 0;
  // Control one field positions
  localparam int CON1_DISSDO = 11;
  localparam int CON1_M16    = 10;
  localparam int CON1_SMP    = 9;
  localparam int CON1_CKE    = 8;
  localparam int CON1_SELECT_PIN_ENABLE   = 7;
  localparam int CON1_CKP    = 6;
  localparam int CON1_MST    = 5;
  // Control two field positions
  localparam int CON2_FRM    = 15;
  localparam int CON2_FSD    = 14;
  localparam int CON2_FPOL   = 13;
  localparam int CON2_FEDGE  = 1;
  localparam int CON2_BEN    = 0;
  // Buffer depths and levels
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] STD_DEPTH  = 4'h1;
  localparam logic [3:0] RX_3Q_LVL  = 4'h6;
  localparam logic [4:0] BITS_WORD  = 5'h10;
  localparam logic [4:0] BITS_BYTE  = 5'h08;
  // Master shift clock timing
  localparam int CLK_NS      = 5;
  localparam int SCK_HALF_NS = 20;
  localparam logic [2:0] SCK_HALF_CYC = 3'(SCK_HALF_NS / CLK_NS);
  // Interrupt condition encodings
  localparam logic [2:0] IRQ_TX_FULL  = 3'h7;
  localparam logic [2:0] IRQ_TX_EMPTY = 3'h6;
  localparam logic [2:0] IRQ_TX_DONE  = 3'h5;
  localparam logic [2:0] IRQ_TX_SLOT  = 3'h4;
  localparam logic [2:0] IRQ_RX_FULL  = 3'h3;
  localparam logic [2:0] IRQ_RX_3Q    = 3'h2;
  localparam logic [2:0] IRQ_RX_AVAIL = 3'h1;
  localparam logic [2:0] IRQ_RX_DRAIN = 3'h0;
  // Synchroniser bit positions
  localparam int PIN_SCK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_SS  = 2;
  // Shifter states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FRAME = 3'h2,
    ST_SHIFT = 3'h4
  } spf_state_t;
endpackage

// ### hdl/spf_port.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - One buffer standard; eight-entry FIFO enhanced
// - Supports 4-pin, 3-pin and 2-pin use
// - Framed mode in master and slave roles
// - Master starts transfer on buffer write
// - Enable bit drives pins; clear disables port
// - Idle-stop bit freezes port in idle
// - Element count: pending or unread words
// - Shifter-empty flag reads shifter idle
// - Overflow discards word, flag sticky until cleared
// - Receive-empty flag reads empty receive FIFO
// - Transmit interrupt conditions 111 to 100
// - Receive interrupt conditions 011 to 000
// - Transmit-full sets on last slot, clears on free
// - Receive-full sets on last slot, clears on read
// - Word-width bit picks 16 or 8 bits
// - Polarity bit sets idle clock level
module spf_port (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        idleMode,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        sdiIn,
  output logic             sdoOut,
  output logic             sdoOe,
  input  wire logic        ssIn,
  output logic             ssOut,
  output logic             ssOe,
  output logic             portIrqFlag
);
  import spf_pkg::*;
  // Every check below runs on the core clock and rests in reset
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Configuration bits
  logic enR, enNxt, sidlR, sidlNxt, rovR, rovNxt;
  logic [2:0] siselR, siselNxt;
  logic m16R, m16Nxt, smpR, smpNxt, ckeR, ckeNxt, ssenR, ssenNxt;
  logic ckpR, ckpNxt, mstR, mstNxt, dissdoR, dissdoNxt;
  logic frmR, frmNxt, fsdR, fsdNxt, fpolR, fpolNxt, fedgeR, fedgeNxt, benR, benNxt;
  // FIFO storage and pointers
  logic [15:0] txMem [8];
  logic [15:0] rxMem [8];
  logic [2:0]  txWpR, txWpNxt, txRpR, txRpNxt, rxWpR, rxWpNxt, rxRpR, rxRpNxt;
  logic [3:0]  txCntR, txCntNxt, rxCntR, rxCntNxt;
  // Shifter and pins
  spf_state_t  stR, stNxt;
  logic [15:0] shR, shNxt, rxData, shIn;
  logic [4:0]  bitR, bitNxt, bitAfter, bits;
  logic [2:0]  divR, divNxt;
  logic [1:0]  frmCntR, frmCntNxt;
  logic        sckR, sckNxt, sdoR, sdoNxt, ssR, ssNxt;
  logic        sckOeR, sckOeNxt, sdoOeR, sdoOeNxt, ssOeR, ssOeNxt;
  logic        irqR, irqNxt, condPrevR, cond;
  logic [15:0] rdataR, rdataNxt;
  // Synchronisers: A is first stage, B second, P the edge history
  logic [2:0]  syncA_r, syncB_r, prev_r;
  // Per-cycle events
  logic run, txFull, rxFull, txPush, txPop, rxPush, rxPop, doneEv, loadEv;
  logic tick, edgeEv, newSck, lead, trail, sample, change, sel, frameIn, frameOut, start;
  logic [3:0] cap;

  // Pin synchronisers, two flops plus an edge-history flop per pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          // Start at the pin's idle level; select idles high, so no false edge
          syncA_r[gi] <= (gi == PIN_SS);
          syncB_r[gi] <= (gi == PIN_SS);
          prev_r[gi]  <= (gi == PIN_SS);
        end else begin
          syncA_r[gi] <= (gi == PIN_SCK) ? sckIn : (gi == PIN_SDI) ? sdiIn : ssIn;
          syncB_r[gi] <= syncA_r[gi];
          prev_r[gi]  <= syncB_r[gi];
        end
      end
    end
  endgenerate

  // FIFO storage writes
  always_ff @(posedge core_clk) begin
    if (txPush) txMem[txWpR] <= regWdata;
    if (rxPush) rxMem[rxWpR] <= rxData;
  end

  // Next-state logic for registers, FIFOs and the shifter
  always_comb begin
    {enNxt, sidlNxt, rovNxt, siselNxt} = {enR, sidlR, rovR, siselR};
    {m16Nxt, smpNxt, ckeNxt, ssenNxt, ckpNxt, mstNxt, dissdoNxt} = {m16R, smpR, ckeR, ssenR, ckpR, mstR, dissdoR};
    {frmNxt, fsdNxt, fpolNxt, fedgeNxt, benNxt} = {frmR, fsdR, fpolR, fedgeR, benR};
    {txWpNxt, txRpNxt, rxWpNxt, rxRpNxt} = {txWpR, txRpR, rxWpR, rxRpR};
    {stNxt, shNxt, bitNxt, divNxt, frmCntNxt} = {stR, shR, bitR, divR, frmCntR};
    {sckNxt, sdoNxt, ssNxt} = {sckR, sdoR, ssR};
    {txPush, txPop, rxPush, rxPop, doneEv, loadEv, start} = 7'h00;
    rdataNxt = 16'h0000;
    run      = enR && !(sidlR && idleMode);
    cap      = benR ? FIFO_DEPTH : STD_DEPTH;
    txFull   = txCntR >= cap;
    rxFull   = rxCntR >= cap;
    bits     = m16R ? BITS_WORD : BITS_BYTE;
    frameOut = frmR && !fsdR;
    sel      = !ssenR || !syncB_r[PIN_SS];
    frameIn  = (syncB_r[PIN_SS] == fpolR) && (prev_r[PIN_SS] != fpolR);
    // Clock edges: own divider in master role, synchronised pin in slave role
    tick     = divR == SCK_HALF_CYC - 3'h1;
    edgeEv   = mstR ? tick : (syncB_r[PIN_SCK] != prev_r[PIN_SCK]);
    newSck   = mstR ? ~sckR : syncB_r[PIN_SCK];
    lead     = edgeEv && (newSck != ckpR);
    trail    = edgeEv && (newSck == ckpR);
    sample   = (stR == ST_SHIFT) && (ckeR ? lead : trail);
    change   = (stR == ST_SHIFT) && (ckeR ? trail : lead);
    shIn     = sample ? {shR[14:0], syncB_r[PIN_SDI]} : shR; // Word as it stands after this edge
    bitAfter = sample ? bitR + 5'h01 : bitR;
    rxData   = m16R ? shIn : {8'h00, shIn[7:0]};
    // Register writes
    if (regWr) begin
      case (regAddr)
        REG_STAT: begin
          enNxt    = regWdata[STAT_EN];
          sidlNxt  = regWdata[STAT_SIDL];
          siselNxt = regWdata[STAT_IRQ_CONDITION_SELECT +: 3];
          if (!regWdata[STAT_ROV]) rovNxt = 1'b0;
        end
        REG_CON1: begin
          {dissdoNxt, m16Nxt, smpNxt, ckeNxt} = regWdata[CON1_DISSDO -: 4];
          {ssenNxt, ckpNxt, mstNxt} = regWdata[CON1_SELECT_PIN_ENABLE -: 3];
        end
        REG_CON2: begin
          {frmNxt, fsdNxt, fpolNxt} = regWdata[CON2_FRM -: 3];
          {fedgeNxt, benNxt} = regWdata[CON2_FEDGE -: 2];
        end
        REG_BUF: txPush = enR && !txFull;
        default: ; // Unmapped writes ignored
      endcase
    end
    // Register reads, answered in the next cycle only
    if (regRd) begin
      case (regAddr)
        REG_STAT: begin
          rdataNxt[STAT_EN]        = enR;
          rdataNxt[STAT_SIDL]      = sidlR;
          rdataNxt[STAT_BEC +: 3]  = mstR ? txCntR[2:0] : rxCntR[2:0];
          rdataNxt[STAT_SHIFTER_EMPTY]     = stR == ST_IDLE;
          rdataNxt[STAT_ROV]       = rovR;
          rdataNxt[STAT_RXMPT]     = rxCntR == 4'h0;
          rdataNxt[STAT_IRQ_CONDITION_SELECT +: 3] = siselR;
          rdataNxt[STAT_TBF]       = txFull;
          rdataNxt[STAT_RBF]       = rxFull;
        end
        REG_CON1: begin
          rdataNxt[CON1_DISSDO -: 4] = {dissdoR, m16R, smpR, ckeR};
          rdataNxt[CON1_SELECT_PIN_ENABLE -: 3]   = {ssenR, ckpR, mstR};
        end
        REG_CON2: begin
          rdataNxt[CON2_FRM -: 3]   = {frmR, fsdR, fpolR};
          rdataNxt[CON2_FEDGE -: 2] = {fedgeR, benR};
        end
        REG_BUF: begin
          rdataNxt = rxMem[rxRpR];
          rxPop    = rxCntR != 4'h0;
        end
        default: ; // Unmapped reads return zero
      endcase
    end
    // Shifter sequencing, frozen while not running
    if (run) begin
      case (stR)
        ST_IDLE: begin
          divNxt = 3'h0;
          sckNxt = ckpR;
          start = mstR ? (txCntR != 4'h0) && (!(frmR && fsdR) || frameIn)
                       : frmR ? (fsdR ? frameIn : (txCntR != 4'h0)) : sel;
          if (start) begin
            shNxt     = (txCntR != 4'h0) ? txMem[txRpR] : 16'h0000;
            txPop     = txCntR != 4'h0;
            loadEv    = txPop;
            sdoNxt    = m16R ? shNxt[15] : shNxt[7];
            bitNxt    = 5'h00;
            frmCntNxt = 2'h0;
            ssNxt     = frameOut ? fpolR : ~fpolR;
            stNxt     = (frameOut && !fedgeR) ? ST_FRAME : ST_SHIFT;
          end
        end
        ST_FRAME: begin
          // Frame pulse stands for one bit time before the first clock
          divNxt = tick ? 3'h0 : divR + 3'h1;
          if (tick) begin
            frmCntNxt = frmCntR + 2'h1;
            if (frmCntR == 2'h1) begin
              ssNxt = ~fpolR;
              stNxt = ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          if (!mstR && !frmR && !sel) begin
            stNxt = ST_IDLE;
          end else begin
            if (mstR) begin
              divNxt = tick ? 3'h0 : divR + 3'h1;
              sckNxt = tick ? ~sckR : sckR;
            end
            if (trail && frameOut) ssNxt = ~fpolR;
            if (sample) begin
              shNxt  = shIn;
              bitNxt = bitAfter;
            end
            if (change) sdoNxt = m16R ? shR[15] : shR[7];
            if (mstR ? (trail && bitAfter == bits) : (sample && bitAfter == bits)) begin
              doneEv = 1'b1;
              stNxt  = ST_IDLE;
              rovNxt = rovNxt || (rxFull && !rxPop);
              rxPush = !(rxFull && !rxPop);
            end
          end
        end
        default: stNxt = ST_IDLE;
      endcase
    end
    // Pointers and counts
    txWpNxt  = txWpR + {2'h0, txPush};
    txRpNxt  = txRpR + {2'h0, txPop};
    rxWpNxt  = rxWpR + {2'h0, rxPush};
    rxRpNxt  = rxRpR + {2'h0, rxPop};
    txCntNxt = txCntR + {3'h0, txPush} - {3'h0, txPop};
    rxCntNxt = rxCntR + {3'h0, rxPush} - {3'h0, rxPop};
    // Disabled port holds pointers, counts and state cleared, clock and select at their idle levels
    if (!enR) begin
      {txWpNxt, txRpNxt, rxWpNxt, rxRpNxt} = 12'h000;
      {txCntNxt, rxCntNxt} = 8'h00;
      stNxt  = ST_IDLE;
      sckNxt = ckpR;
      ssNxt  = ~fpolR;
    end
    // Interrupt condition: level or event chosen by the select field
    case (siselR)
      IRQ_TX_FULL:  cond = txCntNxt >= cap;
      IRQ_TX_EMPTY: cond = loadEv && txCntNxt == 4'h0;
      IRQ_TX_DONE:  cond = doneEv;
      IRQ_TX_SLOT:  cond = loadEv;
      IRQ_RX_FULL:  cond = rxCntNxt >= cap;
      IRQ_RX_3Q:    cond = rxCntNxt >= RX_3Q_LVL;
      IRQ_RX_AVAIL: cond = rxCntNxt != 4'h0;
      IRQ_RX_DRAIN: cond = rxPop && rxCntNxt == 4'h0;
      default:      cond = 1'b0;
    endcase
    irqNxt   = benR ? (cond && !condPrevR) : doneEv;
    sckOeNxt = enR && mstR;
    sdoOeNxt = enR && !dissdoR;
    ssOeNxt  = enR && frameOut;
  end

  // State registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {enR, sidlR, rovR, siselR} <= 6'h00;
      {m16R, smpR, ckeR, ssenR, ckpR, mstR, dissdoR} <= 7'h00;
      {frmR, fsdR, fpolR, fedgeR, benR} <= 5'h00;
      {txWpR, txRpR, rxWpR, rxRpR} <= 12'h000;
      {txCntR, rxCntR} <= 8'h00;
      stR     <= ST_IDLE;
      shR     <= 16'h0000;
      {bitR, divR, frmCntR} <= 10'h000;
      {sckR, sdoR} <= 2'h0;
      ssR     <= 1'b1;
      {sckOeR, sdoOeR, ssOeR, irqR, condPrevR} <= 5'h00;
      rdataR  <= 16'h0000;
    end else begin
      {enR, sidlR, rovR, siselR} <= {enNxt, sidlNxt, rovNxt, siselNxt};
      {m16R, smpR, ckeR, ssenR, ckpR, mstR, dissdoR} <= {m16Nxt, smpNxt, ckeNxt, ssenNxt, ckpNxt, mstNxt, dissdoNxt};
      {frmR, fsdR, fpolR, fedgeR, benR} <= {frmNxt, fsdNxt, fpolNxt, fedgeNxt, benNxt};
      {txWpR, txRpR, rxWpR, rxRpR} <= {txWpNxt, txRpNxt, rxWpNxt, rxRpNxt};
      {txCntR, rxCntR} <= {txCntNxt, rxCntNxt};
      stR     <= stNxt;
      shR     <= shNxt;
      {bitR, divR, frmCntR} <= {bitNxt, divNxt, frmCntNxt};
      {sckR, sdoR, ssR} <= {sckNxt, sdoNxt, ssNxt};
      {sckOeR, sdoOeR, ssOeR} <= {sckOeNxt, sdoOeNxt, ssOeNxt};
      {irqR, condPrevR} <= {irqNxt, cond};
      rdataR  <= rdataNxt;
    end
  end

  // Outputs straight from flops
  assign regRdata    = rdataR;
  assign sckOut      = sckR;
  assign sdoOut      = sdoR;
  assign ssOut       = ssR;
  assign sckOe       = sckOeR;
  assign sdoOe       = sdoOeR;
  assign ssOe        = ssOeR;
  assign portIrqFlag = irqR;

  // Checks
  property p_rovSticky; rovR && !(regWr && regAddr == REG_STAT && !regWdata[STAT_ROV]) |=> rovR; endproperty
  a_rovSticky: assert property (p_rovSticky) else $error("overflow flag dropped");
  property p_masterStart; regWr && regAddr == REG_BUF && enR && mstR && !frmR && txCntR == 4'h0 && stR == ST_IDLE
    && !sidlR ##1 enR |-> ##1 stR == ST_SHIFT; endproperty
  a_masterStart: assert property (p_masterStart) else $error("master did not start");
  property p_disabledPins; !enR |=> !sckOe && !sdoOe && !ssOe; endproperty
  a_disabledPins: assert property (p_disabledPins) else $error("pins driven while disabled");
  property p_idleStop; enR && sidlR && idleMode |=> $stable(shR) && $stable(bitR); endproperty
  a_idleStop: assert property (p_idleStop) else $error("shifter moved in idle");
  property p_rxEmptyRead; regRd && regAddr == REG_STAT
    |=> regRdata[STAT_RXMPT] == ($past(rxCntR) == 4'h0); endproperty
  a_rxEmptyRead: assert property (p_rxEmptyRead) else $error("receive empty wrong");
  property p_byteWidth; stR == ST_SHIFT && !m16R |-> bitR <= BITS_BYTE; endproperty
  a_byteWidth: assert property (p_byteWidth) else $error("byte transfer too long");
  property p_stdIrq; !benR && doneEv |=> portIrqFlag ##1 !portIrqFlag; endproperty
  a_stdIrq: assert property (p_stdIrq) else $error("no standard interrupt");
  property p_idleClock; (enR && mstR && stR == ST_IDLE && $stable(ckpR))[*2] |-> sckOut == ckpR; endproperty
  a_idleClock: assert property (p_idleClock) else $error("idle clock level wrong");
  property p_stdDepth; !benR && $stable(benR) |-> txCntR <= STD_DEPTH && rxCntR <= STD_DEPTH; endproperty
  a_stdDepth: assert property (p_stdDepth) else $error("standard buffer overfilled");
  c_done: cover property (doneEv && mstR);
  c_slaveDone: cover property (doneEv && !mstR);
  c_overflow: cover property ($rose(rovR));
  c_fifoFull: cover property (benR && txCntR == FIFO_DEPTH);
endmodule
